// [logic/oad_pkg.sv]
// Shared constants and carrier types for the operand addressing decoder
package oad_pkg;

    // Data widths
    localparam int ACC_W = 4;
    localparam int PAIR_W = 8;
    localparam int BITPOS_W = 2;
    localparam int BANK_W = 4;
    localparam int DADDR_W = 8;
    localparam int PC_W = 12;
    localparam int SCALL_W = 11;

    // Data-memory banks
    localparam logic [3:0] BANK_LOW = 4'h0;
    localparam logic [3:0] BANK_HIGH = 4'hF;
    localparam logic [7:0] LOW_AREA_TOP = 8'h7F;

    // Fast and peripheral memory windows
    localparam logic [11:0] FMEM_A_LO = 12'hFB0;
    localparam logic [11:0] FMEM_A_HI = 12'hFBF;
    localparam logic [11:0] FMEM_B_LO = 12'hFF0;
    localparam logic [11:0] FMEM_B_HI = 12'hFFF;
    localparam logic [11:0] PMEM_LO = 12'hFC0;
    localparam logic [11:0] PMEM_HI = 12'hFFF;

    // Table-call vector window
    localparam logic [11:0] TADDR_LO = 12'h020;
    localparam logic [11:0] TADDR_HI = 12'h07F;

    // Short relative branch reach
    localparam int REL_BACK_MIN = -15;
    localparam int REL_BACK_MAX = -1;
    localparam int REL_FWD_MIN = 2;
    localparam int REL_FWD_MAX = 16;

    // Extra machine cycles for a skip
    localparam logic [1:0] SKIP_NONE = 2'h0;
    localparam logic [1:0] SKIP_SHORT = 2'h1;
    localparam logic [1:0] SKIP_LONG = 2'h2;

    // Reset values
    localparam logic [7:0] RST_PAIR = 8'h00;
    localparam logic [1:0] RST_SKIP = 2'h0;

    typedef enum logic [2:0] {
        DM_DIRECT = 3'h0,
        DM_PTR_PAIR = 3'h1,
        DM_PTR_GROUP = 3'h2,
        DM_FAST = 3'h3,
        DM_PERIPH = 3'h4
    } oad_dmode_t;

    typedef enum logic [1:0] {
        PM_TABLE_CALL = 2'h0,
        PM_PAGE_CALL = 2'h1,
        PM_SHORT_CALL = 2'h2,
        PM_REL_BRANCH = 2'h3
    } oad_pmode_t;

    typedef struct packed {
        logic valid;
        oad_dmode_t mode;
        logic [11:0] operand;
        logic [7:0] pointer;
        logic wide;
        logic [1:0] bitPos;
        logic useCarry;
        logic [3:0] readNibble;
    } oad_data_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [3:0] activeDataBank;
        logic [7:0] addr;
        logic [3:0] bitSelect;
        logic bitValue;
    } oad_data_rsp_t;

    typedef struct packed {
        logic valid;
        oad_pmode_t mode;
        logic [11:0] operand;
        logic [11:0] pc;
    } oad_pc_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [11:0] target;
    } oad_pc_rsp_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic absoluteBranchOp;
        logic absoluteRangeBranchOp;
        logic absoluteCallOp;
        logic absoluteRangeCallOp;
    } oad_skip_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] extraCycles;
        logic busy;
    } oad_skip_rsp_t;

endpackage : oad_pkg

// [logic/oad_operand_decoder.sv]
// Operand decoder: data-bank selection, program address checks, skip cost
// Contract
// RQ1: The accumulator is 4 bits and the paired accumulator joins two nibbles into 8 bits.
// RQ2: The carry bit acts as a one-bit accumulator usable as bit-operand source or destination.
// RQ3: An 8-bit transfer through a direct memory operand may only address an even nibble location.
// RQ4: The bit-position field is 2 bits and picks one of four bits in a nibble.
// RQ5: Indirect accesses through the pointer group always use bank 0, whatever the bank state.
// RQ6: Fast and peripheral operands always use bank 15 and must lie inside their fixed windows.
// RQ7: Direct and pointer-pair accesses use the selected bank if enabled, else bank 0 or 15.
// RQ8: A table-call operand must be an even vector address from 20H to 7FH.
// RQ9: The in-page call operand is a 12-bit field and the short call operand an 11-bit field.
// RQ10: A short relative branch target lies 15 to 1 below or 2 to 16 above the current address.
// RQ11: A skip instruction that does not skip costs no extra machine cycle.
// RQ12: Skipping a one- or two-byte instruction costs one extra machine cycle.
// RQ13: Skipping a three-byte instruction costs two extra machine cycles.
// RQ14: Exactly the four absolute branch and call forms count as three-byte instructions.
`timescale 1ns/1ps
module oad_operand_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bank state
    input wire logic bankEnableFlag,
    input wire logic [3:0] bankSelectRegister,
    // Accumulator nibbles and carry
    input wire logic [oad_pkg::ACC_W-1:0] accLow,
    input wire logic [oad_pkg::ACC_W-1:0] accHigh,
    input wire logic carryBit,
    // Data operand request and answer
    input wire oad_pkg::oad_data_req_t dataReq,
    output oad_pkg::oad_data_rsp_t dataRsp,
    output logic [oad_pkg::PAIR_W-1:0] pairedAccumulator,
    // Program operand request and answer
    input wire oad_pkg::oad_pc_req_t pcReq,
    output oad_pkg::oad_pc_rsp_t pcRsp,
    // Skip request and answer
    input wire oad_pkg::oad_skip_req_t skipReq,
    output oad_pkg::oad_skip_rsp_t skipRsp
);
    import oad_pkg::*;

    typedef struct packed {
        oad_data_rsp_t data;
        oad_pc_rsp_t pc;
        oad_skip_rsp_t skip;
        logic [1:0] skipLeft;
        logic [PAIR_W-1:0] pair;
    } oad_state_t;

    oad_state_t state_q;
    oad_state_t state_d;

    function automatic logic inWindow(input logic [11:0] a, input logic [11:0] lo,
                                      input logic [11:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : inWindow

    // Bank for direct and pointer-pair operands
    function automatic logic [3:0] pagedBank(input logic en, input logic [3:0] sel,
                                             input logic [7:0] a);
        logic [3:0] b;
        b = BANK_LOW;
        if (en) begin
            b = sel; // RQ7
        end else if (a > LOW_AREA_TOP) begin
            b = BANK_HIGH; // RQ7
        end
        return b;
    endfunction : pagedBank

    function automatic logic relReach(input logic [11:0] pc, input logic [11:0] t);
        logic signed [12:0] d;
        d = $signed({1'b0, t}) - $signed({1'b0, pc});
        return ((d >= REL_BACK_MIN) && (d <= REL_BACK_MAX)) ||
               ((d >= REL_FWD_MIN) && (d <= REL_FWD_MAX)); // RQ10
    endfunction : relReach

    logic threeByte;
    logic [11:0] fullOp;

    always_comb begin
        state_d = state_q;
        fullOp = dataReq.operand;
        threeByte = skipReq.absoluteBranchOp | skipReq.absoluteRangeBranchOp |
                    skipReq.absoluteCallOp | skipReq.absoluteRangeCallOp; // RQ14

        // Paired accumulator, X high nibble over A low nibble
        state_d.pair = {accHigh, accLow}; // RQ1

        // Data operand
        state_d.data.valid = dataReq.valid;
        if (dataReq.valid) begin
            state_d.data.err = 1'b0;
            state_d.data.bitSelect = 4'h1 << dataReq.bitPos; // RQ4
            // Carry doubles as the bit accumulator
            state_d.data.bitValue = dataReq.useCarry ? carryBit
                                  : dataReq.readNibble[dataReq.bitPos]; // RQ2
            case (dataReq.mode)
                DM_DIRECT: begin
                    state_d.data.addr = fullOp[7:0];
                    state_d.data.activeDataBank =
                        pagedBank(bankEnableFlag, bankSelectRegister, fullOp[7:0]);
                    // Pair transfer needs even base so the odd partner follows
                    if (dataReq.wide && fullOp[0]) begin
                        state_d.data.err = 1'b1; // RQ3
                    end
                end
                DM_PTR_PAIR: begin
                    state_d.data.addr = dataReq.pointer;
                    state_d.data.activeDataBank =
                        pagedBank(bankEnableFlag, bankSelectRegister, dataReq.pointer);
                end
                DM_PTR_GROUP: begin
                    state_d.data.addr = dataReq.pointer;
                    state_d.data.activeDataBank = BANK_LOW; // RQ5
                end
                DM_FAST: begin
                    state_d.data.addr = fullOp[7:0];
                    state_d.data.activeDataBank = BANK_HIGH; // RQ6
                    state_d.data.err = !(inWindow(fullOp, FMEM_A_LO, FMEM_A_HI) ||
                                         inWindow(fullOp, FMEM_B_LO, FMEM_B_HI)); // RQ6
                end
                DM_PERIPH: begin
                    state_d.data.addr = fullOp[7:0];
                    state_d.data.activeDataBank = BANK_HIGH; // RQ6
                    state_d.data.err = !inWindow(fullOp, PMEM_LO, PMEM_HI); // RQ6
                end
                default: begin
                    state_d.data.addr = fullOp[7:0];
                    state_d.data.activeDataBank = BANK_LOW;
                    state_d.data.err = 1'b1;
                end
            endcase
        end

        // Program operand
        state_d.pc.valid = pcReq.valid;
        if (pcReq.valid) begin
            state_d.pc.target = pcReq.operand;
            state_d.pc.err = 1'b0;
            case (pcReq.mode)
                PM_TABLE_CALL: begin
                    state_d.pc.err = !inWindow(pcReq.operand, TADDR_LO, TADDR_HI) ||
                                     pcReq.operand[0]; // RQ8
                end
                PM_PAGE_CALL: begin
                    state_d.pc.target = pcReq.operand[PC_W-1:0]; // RQ9
                end
                PM_SHORT_CALL: begin
                    // Upper bit forced low; a set bit is a malformed field
                    state_d.pc.target = {1'b0, pcReq.operand[SCALL_W-1:0]}; // RQ9
                    state_d.pc.err = pcReq.operand[SCALL_W]; // RQ9
                end
                PM_REL_BRANCH: begin
                    state_d.pc.err = !relReach(pcReq.pc, pcReq.operand); // RQ10
                end
                default: begin
                    state_d.pc.err = 1'b1;
                end
            endcase
        end

        // Skip cost; a new request is ignored while a pass-over is running
        state_d.skip.valid = 1'b0;
        if (state_q.skipLeft != 2'h0) begin
            state_d.skipLeft = state_q.skipLeft - 2'h1;
        end else if (skipReq.valid) begin
            state_d.skip.valid = 1'b1;
            if (!skipReq.taken) begin
                state_d.skip.extraCycles = SKIP_NONE; // RQ11
            end else if (threeByte) begin
                state_d.skip.extraCycles = SKIP_LONG; // RQ13
            end else begin
                state_d.skip.extraCycles = SKIP_SHORT; // RQ12
            end
            state_d.skipLeft = state_d.skip.extraCycles;
        end
        state_d.skip.busy = (state_d.skipLeft != 2'h0);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= '0;
            state_q.pair <= RST_PAIR;
            state_q.skipLeft <= RST_SKIP;
        end else begin
            state_q <= state_d;
        end
    end

    assign dataRsp = state_q.data;
    assign pcRsp = state_q.pc;
    assign skipRsp = state_q.skip;
    assign pairedAccumulator = state_q.pair;

endmodule : oad_operand_decoder

// [tb/oad_operand_decoder_sva.sv]
// Port checker for the operand decoder
`timescale 1ns/1ps
module oad_operand_decoder_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Inputs
    input wire logic bankEnableFlag,
    input wire logic [3:0] bankSelectRegister,
    input wire logic [3:0] accLow,
    input wire logic [3:0] accHigh,
    input wire logic carryBit,
    input wire oad_pkg::oad_data_req_t dataReq,
    input wire oad_pkg::oad_pc_req_t pcReq,
    input wire oad_pkg::oad_skip_req_t skipReq,
    // Outputs
    input wire oad_pkg::oad_data_rsp_t dataRsp,
    input wire logic [7:0] pairedAccumulator,
    input wire oad_pkg::oad_pc_rsp_t pcRsp,
    input wire oad_pkg::oad_skip_rsp_t skipRsp
);
    import oad_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire dv = dataReq.valid;
    wire acc = skipReq.valid && !skipRsp.busy;
    wire lng = |skipReq[3:0];
    sequence s_short;
        skipRsp.valid && skipRsp.extraCycles == SKIP_SHORT && skipRsp.busy ##1 !skipRsp.busy;
    endsequence
    sequence s_long;
        skipRsp.valid && skipRsp.extraCycles == SKIP_LONG && skipRsp.busy ##1 skipRsp.busy
            ##1 !skipRsp.busy;
    endsequence
    property p_pair;
        !$past(reset) |-> pairedAccumulator == $past({accHigh, accLow});
    endproperty
    property p_grp;
        dv && dataReq.mode == DM_PTR_GROUP |=> dataRsp.valid && dataRsp.activeDataBank == BANK_LOW;
    endproperty
    property p_high;
        dv && dataReq.mode inside {DM_FAST, DM_PERIPH} |=> dataRsp.activeDataBank == BANK_HIGH;
    endproperty
    property p_sel;
        dv && bankEnableFlag && dataReq.mode inside {DM_DIRECT, DM_PTR_PAIR}
            |=> dataRsp.activeDataBank == $past(bankSelectRegister);
    endproperty
    property p_odd;
        dv && dataReq.mode == DM_DIRECT && dataReq.wide && dataReq.operand[0] |=> dataRsp.err;
    endproperty
    property p_bit;
        dv && !dataReq.useCarry |=> dataRsp.bitSelect == (4'h1 << $past(dataReq.bitPos));
    endproperty
    property p_cy;
        dv && dataReq.useCarry |=> dataRsp.bitValue == $past(carryBit);
    endproperty
    property p_tbl;
        pcReq.valid && pcReq.mode == PM_TABLE_CALL && pcReq.operand[0]
            |=> pcRsp.valid && pcRsp.err;
    endproperty
    property p_sk0;
        acc && !skipReq.taken
            |=> skipRsp.valid && skipRsp.extraCycles == SKIP_NONE && !skipRsp.busy;
    endproperty
    property p_sk1;
        acc && skipReq.taken && !lng |=> s_short;
    endproperty
    property p_sk2;
        acc && skipReq.taken && lng |=> s_long;
    endproperty
    a_pair: assert property (p_pair) else $error("paired accumulator wrong");
    a_grp: assert property (p_grp) else $error("pointer group bank wrong");
    a_high: assert property (p_high) else $error("fast or peripheral bank wrong");
    a_sel: assert property (p_sel) else $error("selected bank not used");
    a_odd: assert property (p_odd) else $error("odd wide direct not flagged");
    a_bit: assert property (p_bit) else $error("bit select wrong");
    a_cy: assert property (p_cy) else $error("carry bit operand wrong");
    a_tbl: assert property (p_tbl) else $error("odd table vector not flagged");
    a_sk0: assert property (p_sk0) else $error("no skip cost wrong");
    a_sk1: assert property (p_sk1) else $error("short skip cost wrong");
    a_sk2: assert property (p_sk2) else $error("long skip cost wrong");
endmodule : oad_operand_decoder_sva
bind oad_operand_decoder oad_operand_decoder_sva oad_sva_u (.clk_sys(clk_sys), .reset(reset),
    .bankEnableFlag(bankEnableFlag), .bankSelectRegister(bankSelectRegister), .accLow(accLow),
    .accHigh(accHigh), .carryBit(carryBit), .dataReq(dataReq), .pcReq(pcReq), .skipReq(skipReq),
    .dataRsp(dataRsp), .pairedAccumulator(pairedAccumulator), .pcRsp(pcRsp), .skipRsp(skipRsp));

// [tb/tb_top.sv]
// Random and corner-case bench for the operand decoder
`timescale 1ns/1ps
module tb_top;
    import oad_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic bankEnableFlag = 1'b0;
    logic carryBit = 1'b0;
    logic [3:0] bankSelectRegister = 4'h0, accLow = 4'h0, accHigh = 4'h0;
    oad_data_req_t dataReq = '0, sD = '0, d;
    oad_pc_req_t pcReq = '0, sP = '0, p;
    oad_skip_req_t skipReq = '0, s;
    oad_data_rsp_t dataRsp;
    oad_pc_rsp_t pcRsp;
    oad_skip_rsp_t skipRsp;
    logic [7:0] pairedAccumulator, sA8 = 8'h00;
    logic [3:0] sSel;
    logic sEn, sCy, sAcc = 1'b0;
    logic [1:0] eX, expX = 2'h0;
    logic [11:0] corner [7] = '{12'hFAF, 12'hFB0, 12'hFBF, 12'hFC0, 12'hFEF, 12'hFF0, 12'hFFF};
    int err_total = 0, checked = 0, seed = 32'hfd19, cnt = 0, i, k;
    logic [31:0] r;
    oad_operand_decoder dut_u (.clk_sys(clk_sys), .reset(reset), .bankEnableFlag(bankEnableFlag),
        .bankSelectRegister(bankSelectRegister), .accLow(accLow), .accHigh(accHigh),
        .carryBit(carryBit), .dataReq(dataReq), .dataRsp(dataRsp),
        .pairedAccumulator(pairedAccumulator), .pcReq(pcReq), .pcRsp(pcRsp),
        .skipReq(skipReq), .skipRsp(skipRsp));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    function automatic logic [3:0] fBank(oad_data_req_t q, logic en, logic [3:0] sel);
        logic [7:0] a;
        a = (q.mode == DM_DIRECT) ? q.operand[7:0] : q.pointer;
        if (q.mode == DM_PTR_GROUP) return BANK_LOW;
        if (q.mode inside {DM_FAST, DM_PERIPH}) return BANK_HIGH;
        return en ? sel : (a <= LOW_AREA_TOP ? BANK_LOW : BANK_HIGH);
    endfunction : fBank
    function automatic logic fErr(oad_data_req_t q);
        case (q.mode)
            DM_DIRECT: return q.wide & q.operand[0];
            DM_PTR_PAIR, DM_PTR_GROUP: return 1'b0;
            DM_FAST: return !(q.operand inside {[FMEM_A_LO:FMEM_A_HI], [FMEM_B_LO:FMEM_B_HI]});
            DM_PERIPH: return q.operand < PMEM_LO;
            default: return 1'b1;
        endcase
    endfunction : fErr
    function automatic logic pErr(oad_pc_req_t q);
        int dd;
        // Distance without wrap: the reach does not fold around the address space
        dd = int'(q.operand) - int'(q.pc);
        case (q.mode)
            PM_TABLE_CALL: return q.operand[0] || q.operand < TADDR_LO || q.operand > TADDR_HI;
            PM_PAGE_CALL: return 1'b0;
            PM_SHORT_CALL: return q.operand[11];
            default: return !(dd inside {[REL_BACK_MIN:REL_BACK_MAX], [REL_FWD_MIN:REL_FWD_MAX]});
        endcase
    endfunction : pErr
    // One cycle: drive at the edge, judge the previous edge's answers at the falling edge
    task automatic step(input oad_data_req_t dn, input oad_pc_req_t pn, input oad_skip_req_t sn);
        logic [31:0] x;
        x = $random(seed);
        @(posedge clk_sys);
        dataReq <= dn;
        pcReq <= pn;
        skipReq <= sn;
        bankEnableFlag <= x[0];
        bankSelectRegister <= x[4:1];
        accLow <= x[8:5];
        accHigh <= x[12:9];
        carryBit <= x[13];
        @(negedge clk_sys);
        chk("pair", pairedAccumulator, sA8);
        chk("dvalid", dataRsp.valid, sD.valid);
        if (sD.valid) begin
            chk("derr", dataRsp.err, fErr(sD));
            if (sD.mode <= DM_PERIPH)
                chk("bank", dataRsp.activeDataBank, fBank(sD, sEn, sSel));
            chk("addr", dataRsp.addr,
                sD.mode inside {DM_PTR_PAIR, DM_PTR_GROUP} ? sD.pointer : sD.operand[7:0]);
            chk("bitv", dataRsp.bitValue, sD.useCarry ? sCy : sD.readNibble[sD.bitPos]);
            if (!sD.useCarry) chk("bsel", dataRsp.bitSelect, 4'h1 << sD.bitPos);
        end
        chk("pvalid", pcRsp.valid, sP.valid);
        if (sP.valid) begin
            chk("perr", pcRsp.err, pErr(sP));
            chk("tgt", pcRsp.target,
                sP.mode == PM_SHORT_CALL ? {1'b0, sP.operand[10:0]} : sP.operand);
        end
        if (sAcc) cnt = eX;
        else if (cnt > 0) cnt--;
        if (sAcc) expX = eX;
        chk("svalid", skipRsp.valid, sAcc);
        chk("extra", skipRsp.extraCycles, expX);
        chk("busy", skipRsp.busy, cnt != 0);
        sD = dataReq;
        sP = pcReq;
        sEn = bankEnableFlag;
        sSel = bankSelectRegister;
        sCy = carryBit;
        sA8 = {accHigh, accLow};
        sAcc = skipReq.valid && cnt == 0;
        eX = !skipReq.taken ? SKIP_NONE : (|skipReq[3:0] ? SKIP_LONG : SKIP_SHORT);
    endtask : step
    initial begin
        // Third edge still sees reset high, so reset spans three edges
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("rst", {dataRsp.valid, pcRsp.valid, skipRsp}, 12'h000);
        chk("rstpair", pairedAccumulator, 12'h000);
        @(posedge clk_sys);
        reset <= 1'b0;
        for (k = -16; k < 18; k++) step('0, '{1'b1, PM_REL_BRANCH, 12'(256 + k), 12'h100}, '0);
        for (k = 28; k < 130; k++) step('0, '{1'b1, PM_TABLE_CALL, 12'(k), 12'h000}, '0);
        for (k = 0; k < 14; k++) step('{1'b1, k[0] ? DM_PERIPH : DM_FAST, corner[k/2], 8'h00,
            1'b0, 2'h0, 1'b0, 4'h0}, '0, '0);
        for (k = 0; k < 5; k++) begin
            s = '{1'b1, 1'b1, k == 0, k == 1, k == 2, k == 3};
            step('0, '0, s);
            step('0, '0, s);
            repeat (3) step('0, '0, '0);
        end
        for (i = 0; i < 4000; i++) begin
            r = $random(seed);
            d = $random(seed);
            p = 27'($random(seed));
            s = 6'(r);
            if (d.mode[2:1] == 2'b11) d.mode = DM_FAST;
            if (r[31]) d.operand[11:8] = 4'hF;
            if (p.mode == PM_REL_BRANCH) p.operand = p.pc + 12'(r[12:8]) - 12'h010;
            if (p.mode == PM_TABLE_CALL) p.operand = 12'(r[19:13]);
            if (cnt == 1) s.valid = 1'b0;
            step(d, p, s);
        end
        report_and_stop();
    end
endmodule : tb_top
